// ---- hw/failsafe_pkg.sv ----
package failsafe_pkg;

    // ********************************************************************
    // serial frame layout: rw flag, 7-bit address, 16-bit data
    // ********************************************************************
    localparam int FRAME_BITS = 24;
    localparam int ADDR_BITS = 8;
    localparam int DATA_BITS = 16;
    localparam int FRAME_RW_BIT = 23;
    localparam logic [6:0] GSR_ADDR = 7'h00;
    localparam logic [6:0] CTRL_ADDR = 7'h01;
    localparam logic [6:0] SR3_ADDR = 7'h02;

    // ********************************************************************
    // register fields and reset values
    // ********************************************************************
    localparam int CTRL_WATCHDOG_TRIGGER_BIT_BIT = 0;
    localparam int CTRL_FSO_NORMAL_BIT = 1;
    localparam int CTRL_LOAD_LSB = 2;
    localparam int LOAD_W = 6;
    localparam int CTRL_WAKE_LSB = 8;
    localparam int WAKE_W = 8;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam int GSR_FAILSAFE_BIT = 0;
    localparam int GSR_CAUSE_LSB = 1;
    localparam int CAUSE_WD = 0;
    localparam int CAUSE_UV = 1;
    localparam int CAUSE_TSD = 2;
    localparam int CAUSE_SPI = 3;
    localparam int CAUSE_FORCED = 4;
    localparam int CAUSE_W = 5;
    localparam int SR3_TW = 0;
    localparam int SR3_THERMAL_SHUTDOWN_LEVEL1 = 1;
    localparam int SR3_THERMAL_SHUTDOWN_LEVEL2 = 2;
    localparam int SR3_FORCED_WD = 3;
    localparam int SR3_FORCED_TS = 4;
    localparam int SR3_REG_FAIL = 5;
    localparam int SR3_W = 6;
    localparam int SR3_WDCNT_LSB = 8;
    localparam int SR3_TSDCNT_LSB = 12;

    // ********************************************************************
    // escalation counts and timing
    // ********************************************************************
    localparam logic [3:0] WD_REGOFF_COUNT = 4'h8;
    localparam logic [3:0] WD_FORCED_COUNT = 4'hf;
    localparam logic [2:0] TSD_FORCED_COUNT = 3'h7;
    localparam int CLK_PERIOD_NS = 5;
    localparam int REG_OFF_MS = 200;
    localparam int REG_OFF_CYC = REG_OFF_MS * 1000000 / CLK_PERIOD_NS;
    localparam int UV_FILTER_NS = 10000;
    localparam int UV_FILTER_CYC = (UV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAIL_FILTER_NS = 10000;
    localparam int FAIL_FILTER_CYC = (FAIL_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_PERIOD_NS = 125;
    localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

    typedef enum logic [1:0]
    {
        ST_RUN = 2'b00,
        ST_FAILSAFE = 2'b01,
        ST_REG_OFF = 2'b10,
        ST_FORCED = 2'b11
    } sup_state_e;

endpackage

// ---- hw/serial_link_if.sv ----
interface serial_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;

    modport host_end (output sclk, output cs_n, output mosi, input miso);
    modport dev_end (input sclk, input cs_n, input mosi, output miso);
endinterface

// ---- hw/fs_host.sv ----
module fs_host
    import failsafe_pkg::*;
(
    input wire logic ref_clk_i, // 200 MHz clock
    input wire logic sys_rst_i, // async reset, active high
    serial_link_if.host_end link, // serial link to the device
    input wire logic addr_i, // 0: frame port
    input wire logic [23:0] wdata_i, // frame to send
    input wire logic wr_i, // write strobe, starts a frame
    input wire logic rd_i, // read strobe
    output logic [31:0] rdata_o // {busy, last answer}, one cycle later
);

    // ********************************************************************
    // state
    // ********************************************************************
    typedef struct packed {
        logic [7:0] div_cnt;
        logic sclk;
        logic cs_n;
        logic mosi;
        logic [23:0] tx;
        logic [15:0] rx;
        logic [4:0] bitn;
        logic busy;
        logic miso_s1;
        logic miso_s2;
        logic [31:0] rdata;
    } host_s;

    host_s q_reg, q_next;
    logic tick;

    always_comb
    begin
        q_next = q_reg;
        q_next.miso_s1 = link.miso;
        q_next.miso_s2 = q_reg.miso_s1;
        tick = (q_reg.div_cnt == 8'(SCLK_HALF_CYC - 1));
        q_next.div_cnt = tick ? 8'h00 : q_reg.div_cnt + 8'h01;
        if (rd_i)
        begin
            q_next.rdata = (addr_i == 1'b0) ? {15'h0000, q_reg.busy, q_reg.rx} : 32'h00000000;
        end
        if (!q_reg.busy)
        begin
            if (wr_i && addr_i == 1'b0)
            begin
                // a write while a frame runs is dropped
                q_next.busy = 1'b1;
                q_next.cs_n = 1'b0;
                q_next.tx = wdata_i;
                q_next.mosi = wdata_i[23];
                q_next.bitn = 5'h00;
                q_next.div_cnt = 8'h00;
            end
        end
        else if (tick)
        begin
            // the last falling edge comes before chip select rises, so the clock idles low
            if (q_reg.sclk)
            begin
                q_next.sclk = 1'b0;
                q_next.tx = {q_reg.tx[22:0], 1'b0};
                q_next.mosi = q_reg.tx[22];
            end
            else if (q_reg.bitn == 5'd25)
            begin
                q_next.busy = 1'b0;
            end
            else if (q_reg.bitn == 5'd24)
            begin
                // one idle half period keeps chip select high long enough to be seen
                q_next.cs_n = 1'b1;
                q_next.bitn = 5'd25;
            end
            else
            begin
                q_next.sclk = 1'b1;
                q_next.rx = {q_reg.rx[14:0], q_reg.miso_s2};
                q_next.bitn = q_reg.bitn + 5'h01;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            q_reg <= '0;
            q_reg.cs_n <= 1'b1;
        end
        else
        begin
            q_reg <= q_next;
        end
    end

    assign link.sclk = q_reg.sclk;
    assign link.cs_n = q_reg.cs_n;
    assign link.mosi = q_reg.mosi;
    assign rdata_o = q_reg.rdata;

endmodule

// ---- hw/fs_device.sv ----
// Local design decisions: the placing of the registers and the plain strobed port.
module fs_device
    import failsafe_pkg::*;
#(
    parameter int REG_OFF_CYCLES = REG_OFF_CYC
)
(
    input wire logic ref_clk_i, // 200 MHz clock
    input wire logic sys_rst_i, // async reset, active high
    serial_link_if.dev_end link, // serial link from the host
    input wire logic watchdog_failure_count_i, // watchdog failure pulse, same clock
    input wire logic long_window_i, // watchdog in long open window
    input wire logic standby_i, // regulator_on_standby mode active
    input wire logic wd_running_i, // load above load_current_threshold
    input wire logic reg_low_i, // main_regulator below fail level, async
    input wire logic reg_uv_i, // main_regulator below reset_threshold, async
    input wire logic tw_i, // thermal warning level, async
    input wire logic thermal_shutdown_level1_i, // thermal shutdown level 1, async
    input wire logic thermal_shutdown_level2_i, // thermal shutdown level 2, async
    input wire logic wake_i, // regular wake-up event, async
    output logic failsafe_o, // failsafe active
    output logic [LOAD_W-1:0] load_en_o, // load output enables
    output logic [WAKE_W-1:0] wake_frame_o, // programmed wake-up frame
    output logic fso_drive_o, // failsafe_output_pin high-side on
    output logic fso_normal_o, // pin in normal driver mode
    output logic periph_on_o, // transmitters, amplifiers, serial on
    output logic reg_off_o, // main_regulator switched off
    output logic batt_standby_o, // forced battery_standby
    output logic reset_pulse_o // reset request to host, one cycle
);

    // ********************************************************************
    // state
    // ********************************************************************
    typedef struct packed {
        sup_state_e state;
        logic [2:0] sclk_s;
        logic [2:0] cs_s;
        logic [1:0] mosi_s;
        logic [5:0] an_s1;
        logic [5:0] an_s2;
        logic [23:0] shift_in;
        logic [4:0] bit_cnt;
        logic [15:0] shift_out;
        logic miso;
        logic [15:0] ctrl;
        logic fso_normal;
        logic [CAUSE_W-1:0] cause;
        logic [SR3_W-1:0] sr3;
        logic [3:0] wd_cnt;
        logic [2:0] tsd_cnt;
        logic flag_read;
        logic watchdog_trigger_bit_seen;
        logic turn_on;
        logic thermal_shutdown_level2_prev;
        logic [15:0] uv_cnt;
        logic [15:0] low_cnt;
        logic [31:0] off_cnt;
        logic rst_pulse;
    } dev_s;

    dev_s q_reg, q_next;

    function automatic logic [15:0] read_reg(input dev_s q, input logic [6:0] a);
        logic [15:0] v;
        v = 16'h0000;
        if (a == GSR_ADDR)
        begin
            v[GSR_FAILSAFE_BIT] = (q.state != ST_RUN);
            v[GSR_CAUSE_LSB +: CAUSE_W] = q.cause;
        end
        else if (a == CTRL_ADDR)
        begin
            v = q.ctrl;
            v[CTRL_FSO_NORMAL_BIT] = q.fso_normal;
        end
        else if (a == SR3_ADDR)
        begin
            v[SR3_W-1:0] = q.sr3;
            v[SR3_WDCNT_LSB +: 4] = q.wd_cnt;
            v[SR3_TSDCNT_LSB +: 3] = q.tsd_cnt;
        end
        return v;
    endfunction

    logic sclk_rise, sclk_fall, cs_end, cs_start, cs_act;
    logic frame_ok, stuck, valid_frame, rw;
    logic [6:0] addr;
    logic [15:0] data;
    logic reg_low, reg_uv, thermal_shutdown_level2, wake;
    logic uv_evt, short_evt, tsd_evt, wd_evt, spi_evt, enter;
    logic [CAUSE_W-1:0] new_cause;
    logic [6:0] rd_addr;

    always_comb
    begin
        q_next = q_reg;
        q_next.rst_pulse = 1'b0;
        // ****************************************************************
        // synchronisers: first stage feeds only the second
        // ****************************************************************
        q_next.sclk_s = {q_reg.sclk_s[1:0], link.sclk};
        q_next.cs_s = {q_reg.cs_s[1:0], link.cs_n};
        q_next.mosi_s = {q_reg.mosi_s[0], link.mosi};
        q_next.an_s1 = {reg_low_i, reg_uv_i, tw_i, thermal_shutdown_level1_i, thermal_shutdown_level2_i, wake_i};
        q_next.an_s2 = q_reg.an_s1;
        {reg_low, reg_uv} = q_reg.an_s2[5:4];
        thermal_shutdown_level2 = q_reg.an_s2[1];
        wake = q_reg.an_s2[0];
        sclk_rise = q_reg.sclk_s[1] & ~q_reg.sclk_s[2];
        sclk_fall = ~q_reg.sclk_s[1] & q_reg.sclk_s[2];
        cs_act = ~q_reg.cs_s[1];
        cs_start = ~q_reg.cs_s[1] & q_reg.cs_s[2];
        cs_end = q_reg.cs_s[1] & ~q_reg.cs_s[2];

        // ****************************************************************
        // serial receive and answer
        // ****************************************************************
        rd_addr = {q_reg.shift_in[5:0], q_reg.mosi_s[1]};
        if (cs_start)
        begin
            q_next.bit_cnt = 5'h00;
        end
        else if (cs_act && sclk_rise)
        begin
            q_next.shift_in = {q_reg.shift_in[22:0], q_reg.mosi_s[1]};
            q_next.bit_cnt = q_reg.bit_cnt + 5'h01;
            if (q_reg.bit_cnt == 5'd7)
            begin
                q_next.shift_out = read_reg(q_reg, rd_addr);
            end
        end
        else if (cs_act && sclk_fall && q_reg.bit_cnt >= 5'd8)
        begin
            q_next.miso = q_reg.shift_out[15];
            q_next.shift_out = {q_reg.shift_out[14:0], 1'b0};
        end
        frame_ok = cs_end && (q_reg.bit_cnt == 5'(FRAME_BITS));
        stuck = (q_reg.shift_in == 24'h000000) || (q_reg.shift_in == 24'hffffff);
        spi_evt = frame_ok && stuck;
        valid_frame = frame_ok && !stuck;
        rw = q_reg.shift_in[FRAME_RW_BIT];
        addr = q_reg.shift_in[22:16];
        data = q_reg.shift_in[15:0];
        if (valid_frame && rw && addr == CTRL_ADDR)
        begin
            if (q_reg.state == ST_RUN)
            begin
                q_next.ctrl = data;
                q_next.fso_normal = data[CTRL_FSO_NORMAL_BIT];
            end
            if (data[CTRL_WATCHDOG_TRIGGER_BIT_BIT] && long_window_i)
            begin
                q_next.watchdog_trigger_bit_seen = 1'b1;
            end
        end
        if (valid_frame && rw && addr == SR3_ADDR)
        begin
            q_next.sr3 = q_reg.sr3 & ~data[SR3_W-1:0];
        end
        if (valid_frame && !rw && addr == GSR_ADDR)
        begin
            q_next.flag_read = 1'b1;
        end
        if (valid_frame)
        begin
            q_next.cause[CAUSE_SPI] = 1'b0;
        end

        // ****************************************************************
        // fault filters and events
        // ****************************************************************
        q_next.thermal_shutdown_level2_prev = thermal_shutdown_level2;
        q_next.uv_cnt = (reg_uv && q_reg.uv_cnt != 16'(UV_FILTER_CYC)) ? q_reg.uv_cnt + 16'h0001
            : (reg_uv ? q_reg.uv_cnt : 16'h0000);
        q_next.low_cnt = (reg_low && q_reg.low_cnt != 16'(FAIL_FILTER_CYC))
            ? q_reg.low_cnt + 16'h0001 : (reg_low ? q_reg.low_cnt : 16'h0000);
        if (!reg_low)
        begin
            q_next.turn_on = 1'b0;
        end
        // regulator is off while counting down or in forced standby: no undervoltage event, the short check is not gated
        uv_evt = reg_uv && q_reg.uv_cnt == 16'(UV_FILTER_CYC - 1) && !q_reg.state[1];
        short_evt = q_reg.turn_on && reg_low
            && q_reg.low_cnt == 16'(FAIL_FILTER_CYC - 1);
        tsd_evt = thermal_shutdown_level2 && !q_reg.thermal_shutdown_level2_prev && q_reg.state != ST_FORCED;
        wd_evt = watchdog_failure_count_i && (!standby_i || wd_running_i) && !q_reg.state[1];
        new_cause = '0;
        new_cause[CAUSE_WD] = wd_evt;
        new_cause[CAUSE_UV] = uv_evt;
        new_cause[CAUSE_TSD] = tsd_evt;
        new_cause[CAUSE_SPI] = spi_evt;
        new_cause[CAUSE_FORCED] = short_evt;
        enter = |new_cause;

        // ****************************************************************
        // exit conditions, one per cause except SPI, which any valid frame clears
        // ****************************************************************
        if (q_reg.cause[CAUSE_WD] && q_reg.watchdog_trigger_bit_seen && q_reg.flag_read)
        begin
            q_next.cause[CAUSE_WD] = 1'b0;
            q_next.wd_cnt = 4'h0;
            q_next.tsd_cnt = 3'h0;
        end
        if (q_reg.cause[CAUSE_UV] && !reg_uv && q_reg.flag_read)
        begin
            q_next.cause[CAUSE_UV] = 1'b0;
        end
        if (q_reg.cause[CAUSE_TSD] && !thermal_shutdown_level2 && !q_reg.sr3[SR3_THERMAL_SHUTDOWN_LEVEL2])
        begin
            q_next.cause[CAUSE_TSD] = 1'b0;
        end
        if (q_reg.cause[CAUSE_FORCED] && q_reg.state == ST_FAILSAFE
            && !q_reg.sr3[SR3_FORCED_WD] && !q_reg.sr3[SR3_FORCED_TS])
        begin
            q_next.cause[CAUSE_FORCED] = 1'b0;
        end

        // ****************************************************************
        // supervisor; a new event wins over any clear in the same cycle
        // ****************************************************************
        case (q_reg.state)
            ST_RUN:
            begin
            end
            ST_FAILSAFE:
            begin
                if (q_next.cause == '0 && !enter)
                begin
                    q_next.state = ST_RUN;
                end
            end
            ST_REG_OFF:
            begin
                if (q_reg.off_cnt == 32'h00000000)
                begin
                    q_next.state = ST_FAILSAFE;
                    q_next.turn_on = 1'b1;
                    q_next.rst_pulse = 1'b1;
                end
                else
                begin
                    q_next.off_cnt = q_reg.off_cnt - 32'h00000001;
                end
            end
            ST_FORCED:
            begin
                if (wake)
                begin
                    q_next.state = ST_FAILSAFE;
                    q_next.turn_on = 1'b1;
                    q_next.rst_pulse = 1'b1;
                end
            end
            default:
            begin
                q_next.state = ST_RUN;
            end
        endcase
        if (enter)
        begin
            q_next.state = ST_FAILSAFE;
            q_next.cause = q_next.cause | new_cause;
            q_next.ctrl = CTRL_RESET;
            q_next.flag_read = 1'b0;
            q_next.watchdog_trigger_bit_seen = 1'b0;
            if (wd_evt || uv_evt)
            begin
                q_next.rst_pulse = 1'b1;
            end
            if (uv_evt)
            begin
                q_next.sr3[SR3_REG_FAIL] = 1'b1;
            end
            if (tsd_evt)
            begin
                q_next.sr3[SR3_TW] = 1'b1;
                q_next.sr3[SR3_THERMAL_SHUTDOWN_LEVEL1] = 1'b1;
                q_next.sr3[SR3_THERMAL_SHUTDOWN_LEVEL2] = 1'b1;
                q_next.tsd_cnt = q_reg.tsd_cnt + 3'h1;
                if (q_reg.tsd_cnt + 3'h1 == TSD_FORCED_COUNT)
                begin
                    q_next.sr3[SR3_FORCED_TS] = 1'b1;
                    q_next.cause[CAUSE_FORCED] = 1'b1;
                    q_next.state = ST_FORCED;
                end
            end
            if (short_evt)
            begin
                q_next.sr3[SR3_FORCED_TS] = 1'b1;
                q_next.state = ST_FORCED;
            end
            if (wd_evt)
            begin
                q_next.wd_cnt = q_reg.wd_cnt + 4'h1;
                if (q_reg.wd_cnt + 4'h1 == WD_FORCED_COUNT)
                begin
                    q_next.sr3[SR3_FORCED_WD] = 1'b1;
                    q_next.cause[CAUSE_FORCED] = 1'b1;
                    q_next.state = ST_FORCED;
                end
                else if (q_reg.wd_cnt + 4'h1 == WD_REGOFF_COUNT)
                begin
                    q_next.state = ST_REG_OFF;
                    q_next.off_cnt = 32'(REG_OFF_CYCLES - 1);
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            q_reg <= '0;
            q_reg.cs_s <= 3'b111;
            q_reg.ctrl <= CTRL_RESET;
            q_reg.turn_on <= 1'b1;
            q_reg.rst_pulse <= 1'b1;
        end
        else
        begin
            q_reg <= q_next;
        end
    end

    // ********************************************************************
    // outputs
    // ********************************************************************
    assign link.miso = q_reg.miso;
    assign failsafe_o = (q_reg.state != ST_RUN);
    assign load_en_o = q_reg.ctrl[CTRL_LOAD_LSB +: LOAD_W];
    assign wake_frame_o = q_reg.ctrl[CTRL_WAKE_LSB +: WAKE_W];
    assign fso_drive_o = (q_reg.state != ST_RUN) && !q_reg.fso_normal;
    assign fso_normal_o = q_reg.fso_normal;
    assign periph_on_o = 1'b1;
    assign reg_off_o = q_reg.state[1];
    assign batt_standby_o = (q_reg.state == ST_FORCED);
    assign reset_pulse_o = q_reg.rst_pulse;

endmodule

// ---- sim/fs_link_properties.sv ----
module fs_link_properties
    import failsafe_pkg::*;
(
    input wire logic ref_clk_i, // clock
    input wire logic sys_rst_i, // reset
    input wire logic sclk, // link clock
    input wire logic cs_n, // select, active low
    input wire logic mosi, // host data
    input wire logic miso // device data
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // helper counts
    // ****************************************
    int hi_cnt;
    int rise_cnt;
    logic sclk_q;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            hi_cnt <= 0;
            rise_cnt <= 0;
            sclk_q <= 1'b0;
        end
        else
        begin
            hi_cnt <= sclk ? hi_cnt + 1 : 0;
            rise_cnt <= cs_n ? 0 : rise_cnt + int'(sclk && !sclk_q);
            sclk_q <= sclk;
        end
    end
    property p_idle; cs_n |-> !sclk; endproperty
    a_idle:
        assert property (p_idle) else $error("link clock moved while deselected");
    property p_high; $fell(sclk) |-> hi_cnt == SCLK_HALF_CYC; endproperty
    a_high:
        assert property (p_high) else $error("link clock high phase wrong");
    property p_low; $fell(sclk) && !cs_n |-> !sclk [*8]; endproperty
    a_low:
        assert property (p_low) else $error("link clock low phase short");
    property p_mosi; sclk && $past(sclk) |-> $stable(mosi); endproperty
    a_mosi:
        assert property (p_mosi) else $error("host data moved while clock high");
    property p_miso; !cs_n && sclk && $past(sclk) |-> $stable(miso); endproperty
    a_miso:
        assert property (p_miso) else $error("device data moved while clock high");
    property p_bits; $rose(cs_n) |-> rise_cnt == FRAME_BITS; endproperty
    a_bits:
        assert property (p_bits) else $error("frame bit count wrong");
    property p_gap; $rose(cs_n) |-> cs_n [*8]; endproperty
    a_gap:
        assert property (p_gap) else $error("frames too close");
    property p_len; $fell(cs_n) |-> ##[580:600] $rose(cs_n); endproperty
    a_len:
        assert property (p_len) else $error("frame length wrong");
endmodule

// ---- sim/fail_safe_supervisor_bench.sv ----
module fail_safe_supervisor_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import failsafe_pkg::*;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [23:0] wdata_i = 24'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic watchdog_failure_count_i = 1'b0;
    logic long_window_i = 1'b0;
    logic tw_i = 1'b0;
    logic thermal_shutdown_level1_i = 1'b0;
    logic thermal_shutdown_level2_i = 1'b0;
    logic wake_i = 1'b0;
    logic standby_i = 1'b0;
    logic wd_running_i = 1'b0;
    int pulses = 0;
    logic failsafe_o, fso_drive_o, fso_normal_o, periph_on_o, reg_off_o, batt_standby_o;
    logic reset_pulse_o;
    logic [LOAD_W-1:0] load_en_o;
    logic [WAKE_W-1:0] wake_frame_o;
    logic [19:0] exp_q[$];
    logic [19:0] msk_q[$];
    logic look_st = 1'b0;
    logic look_rd = 1'b0;
    logic rd_q = 1'b0;
    int errors = 0;
    int n_checks = 0;
    wire logic [19:0] stat = {failsafe_o, fso_drive_o, fso_normal_o, periph_on_o, reg_off_o,
        batt_standby_o, load_en_o, wake_frame_o};
    serial_link_if link_if();
    // ****************************************
    // design ends and link checker
    // ****************************************
    fs_host i_fs_host(.ref_clk_i, .sys_rst_i, .link(link_if.host_end), .addr_i(1'b0),
        .wdata_i, .wr_i, .rd_i, .rdata_o);
    fs_device #(.REG_OFF_CYCLES(50)) i_fs_device(.ref_clk_i, .sys_rst_i,
        .link(link_if.dev_end), .watchdog_failure_count_i, .long_window_i, .standby_i,
        .wd_running_i, .reg_low_i(1'b0), .reg_uv_i(1'b0), .tw_i, .thermal_shutdown_level1_i, .thermal_shutdown_level2_i,
        .wake_i, .failsafe_o, .load_en_o, .wake_frame_o, .fso_drive_o, .fso_normal_o,
        .periph_on_o, .reg_off_o, .batt_standby_o, .reset_pulse_o);
    fs_link_properties i_fs_link_properties(.ref_clk_i, .sys_rst_i, .sclk(link_if.sclk),
        .cs_n(link_if.cs_n), .mosi(link_if.mosi), .miso(link_if.miso));
    always #2.5 ref_clk_i = ~ref_clk_i;
    // ****************************************
    // result watcher
    // ****************************************
    always @(posedge ref_clk_i)
    begin
        logic [19:0] got;
        got = look_st ? stat : rdata_o[19:0];
        rd_q <= look_rd;
        if (reset_pulse_o && !sys_rst_i)
            pulses++;
        if (look_st || rd_q)
        begin
            n_checks++;
            if ((got & msk_q[0]) !== (exp_q[0] & msk_q[0]))
            begin
                errors++;
                $display("ERROR at %0t: got %h expected %h", $time, got & msk_q[0],
                    exp_q[0] & msk_q[0]);
            end
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    function automatic logic [19:0] mk(input logic fs, dr, nm, ro, bs, input logic [7:0] ld);
        return {fs, dr, nm, 1'b1, ro, bs, ld[5:0], 8'h00};
    endfunction
    task note(input logic [19:0] e, input logic [19:0] m, input logic rd);
        exp_q.push_back(e);
        msk_q.push_back(m);
        look_st <= !rd;
        look_rd <= rd;
        rd_i <= rd;
        @(posedge ref_clk_i);
        look_st <= 1'b0;
        look_rd <= 1'b0;
        rd_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task st(input logic [19:0] e);
        note(e, 20'hfffff, 1'b0);
    endtask
    // polling reads are not noted, only the busy bit is looked at
    task frame(input logic [23:0] f);
        int n;
        wr_i <= 1'b1;
        wdata_i <= f;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        @(posedge ref_clk_i);
        n = 0;
        do
        begin
            rd_i <= 1'b1;
            @(posedge ref_clk_i);
            rd_i <= 1'b0;
            @(posedge ref_clk_i);
            n++;
        end
        while (rdata_o[16] !== 1'b0 && n < 500);
        if (n >= 500)
            errors++;
        repeat (16) @(posedge ref_clk_i);
    endtask
    task rdreg(input logic [6:0] a, input logic [15:0] e, input logic [15:0] m);
        frame({1'b0, a, 16'h0001});
        note({4'h0, e}, {4'h1, m}, 1'b1);
    endtask
    task fault(input logic t);
        tw_i <= t;
        thermal_shutdown_level1_i <= t;
        thermal_shutdown_level2_i <= t;
        watchdog_failure_count_i <= !t;
        @(posedge ref_clk_i);
        watchdog_failure_count_i <= 1'b0;
        repeat (12) @(posedge ref_clk_i);
        tw_i <= 1'b0;
        thermal_shutdown_level1_i <= 1'b0;
        thermal_shutdown_level2_i <= 1'b0;
        repeat (12) @(posedge ref_clk_i);
    endtask
    task results();
        if (errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #400us;
        errors++;
        results();
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        logic [15:0] cw;
        void'($urandom(32'h03f7));
        cw = {8'($urandom), 6'($urandom_range(1, 63)), 2'b00};
        repeat (6) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        st(mk(0, 0, 0, 0, 0, 0));
        standby_i <= 1'b1;
        fault(1'b0);
        st(mk(0, 0, 0, 0, 0, 0));
        wd_running_i <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            frame({1'b1, CTRL_ADDR, cw});
            st({mk(0, 0, 0, 0, 0, cw[7:2]) | {12'h0, cw[15:8]}});
            frame({24{i[0]}});
            st(mk(1, 1, 0, 0, 0, 0));
            rdreg(GSR_ADDR, 16'h0011, 16'h0011);
            st(mk(0, 0, 0, 0, 0, 0));
        end
        for (int i = 1; i <= 7; i++)
        begin
            fault(1'b1);
            if (i == 1)
                rdreg(SR3_ADDR, 16'h1007, 16'h7007);
            if (i < 7)
                frame({1'b1, SR3_ADDR, 16'h003f});
            if (i < 7)
                st(mk(0, 0, 0, 0, 0, 0));
        end
        st(mk(1, 1, 0, 1, 1, 0));
        wake_i <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        wake_i <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        st(mk(1, 1, 0, 0, 0, 0));
        rdreg(SR3_ADDR, 16'h0010, 16'h0018);
        frame({1'b1, SR3_ADDR, 16'h003f});
        st(mk(0, 0, 0, 0, 0, 0));
        frame({1'b1, CTRL_ADDR, 16'h0002});
        fault(1'b0);
        frame({1'b1, CTRL_ADDR, cw | 16'h0002});
        st(mk(1, 0, 1, 0, 0, 0));
        rdreg(SR3_ADDR, 16'h0100, 16'h0f00);
        frame({1'b1, CTRL_ADDR, 16'h0003});
        rdreg(GSR_ADDR, 16'h0003, 16'h0003);
        st(mk(1, 0, 1, 0, 0, 0));
        long_window_i <= 1'b1;
        frame({1'b1, CTRL_ADDR, 16'h0003});
        rdreg(GSR_ADDR, 16'h0000, 16'h0003);
        st(mk(0, 0, 1, 0, 0, 0));
        for (int i = 1; i <= 15; i++)
        begin
            fault(1'b0);
            if (i == 8)
                st(mk(1, 0, 1, 1, 0, 0));
            if (i == 8)
                repeat (60) @(posedge ref_clk_i);
            if (i == 8)
                st(mk(1, 0, 1, 0, 0, 0));
        end
        st(mk(1, 0, 1, 1, 1, 0));
        wake_i <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        wake_i <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        rdreg(SR3_ADDR, 16'h0f08, 16'h0f18);
        frame({1'b1, CTRL_ADDR, 16'h0001});
        frame({1'b1, SR3_ADDR, 16'h003f});
        rdreg(GSR_ADDR, 16'h0001, 16'h0001);
        st(mk(0, 0, 1, 0, 0, 0));
        n_checks++;
        if (pulses != 32'h14)
        begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, pulses, 32'h14);
        end
        results();
    end
endmodule
